// ### hdl/clock_gate_map.svh
// Register offsets, field positions, reset values and figures of the clock gate bank.
`ifndef CLOCK_GATE_MAP_SVH
`define CLOCK_GATE_MAP_SVH

// Byte offsets of the registers on the APB port.
`define CG_RUN_CLOCK_CONFIG_OFF 12'h060
`define CG_RUN_CLOCK_GATE_0_OFF 12'h100
`define CG_SLEEP_CLOCK_GATE_0_OFF 12'h110
`define CG_DEEP_SLEEP_CLOCK_GATE_0_OFF 12'h120
`define CG_FAULT_STATUS_OFF 12'h130
`define CG_FAULT_MASK_OFF 12'h134

// Bit positions of the unit gates, shared by the gate registers and, except hibernation, by the fault status and mask registers.
`define CG_PWM_BIT 20
`define CG_ADC0_BIT 16
`define CG_HIBERNATION_BIT 6
`define CG_WATCHDOG_BIT 3

// Bit position of the automatic clock gating bit in the run clock configuration register.
`define CG_AUTO_CLOCK_GATING_BIT 27

// Reset values.
`define CG_GATE_RESET 32'h0000_0040
`define CG_CONFIG_RESET 32'h0000_0000
`define CG_FAULT_RESET 32'h0000_0000

// Writable bits of each register; everything else reads as zero.
`define CG_GATE_MASK 32'h0011_0048
`define CG_FAULT_BITS 32'h0011_0008
`define CG_CONFIG_MASK 32'h0800_0000

`endif

// ### hdl/clock_gate_pkg.sv
// Types shared by the clock gate bank and its access guard.
`default_nettype none
package clock_gate_pkg;

    // One flag per gated unit.
    typedef struct packed {
        logic pwm;
        logic adc0;
        logic hibernation;
        logic watchdog;
    } unit_vec_t;

    // Power mode of the system, one-hot.
    typedef enum logic [2:0] {
        MODE_RUN = 3'b001,
        MODE_SLEEP = 3'b010,
        MODE_DEEP_SLEEP = 3'b100
    } power_mode_t;

    // APB request as seen by the slave.
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

endpackage : clock_gate_pkg
`default_nettype wire

// ### hdl/deep_sleep_clock_gate_bank0.sv
// Clock gate bank 0: run, sleep and deep-sleep gate registers with an APB slave and fault interrupt.
//
// Notes on behaviour
// [RQ1] Each implemented gate bit is a clock enable: one clocks the unit, zero leaves it unclocked and disabled.
// [RQ2] A bus access to a unit whose clock is gated off gets a bus fault instead of a normal answer.
// [RQ3] The deep-sleep gate register resets to 0x00000040, all gates off except hibernation.
// [RQ4] Three gate registers exist for this group: one for run, one for sleep, one for deep-sleep.
// [RQ5] The sleep and deep-sleep registers only take effect while the automatic clock gating bit is set.
// [RQ6] Bit 20 is the read/write gate of the pulse-width modulation unit, reset zero.
// [RQ7] Bit 16 is the read/write gate of converter unit 0, reset zero.
// [RQ8] Bit 6 is the read/write gate of the hibernation unit, reset one, and it raises no bus fault.
// [RQ9] Bit 3 is the read/write gate of the watchdog unit, reset zero.
// [RQ10] Reserved bits are read-only zero, and software writes back what it read.
// [RQ11] Software must set the gates of every unit it needs, since they start disabled.
// [RQ12] Outside deep-sleep, or with automatic gating off, this register affects no unit clock.
`include "clock_gate_map.svh"
`default_nettype none
module deep_sleep_clock_gate_bank0 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire clock_gate_pkg::power_mode_t powerMode,
    input wire clock_gate_pkg::unit_vec_t unitAccess,
    output clock_gate_pkg::unit_vec_t unitClkEn,
    output clock_gate_pkg::unit_vec_t unitFault,
    output clock_gate_pkg::unit_vec_t unitGrant,
    output logic irq
);

    // Unpacks the four gate positions of a register word.
    function automatic clock_gate_pkg::unit_vec_t gatesOf(input logic [31:0] word);
        gatesOf.pwm = word[`CG_PWM_BIT];
        gatesOf.adc0 = word[`CG_ADC0_BIT];
        gatesOf.hibernation = word[`CG_HIBERNATION_BIT];
        gatesOf.watchdog = word[`CG_WATCHDOG_BIT];
    endfunction : gatesOf

    // Packs four unit flags back into their register positions; all other bits are zero.
    function automatic logic [31:0] wordOf(input clock_gate_pkg::unit_vec_t units);
        wordOf = 32'h0000_0000;
        wordOf[`CG_PWM_BIT] = units.pwm;
        wordOf[`CG_ADC0_BIT] = units.adc0;
        wordOf[`CG_HIBERNATION_BIT] = units.hibernation;
        wordOf[`CG_WATCHDOG_BIT] = units.watchdog;
    endfunction : wordOf

    logic [31:0] runGate_r;
    logic [31:0] sleepGate_r;
    logic [31:0] deepGate_r;
    logic [31:0] runConfig_r;
    logic [31:0] faultStatus_r;
    logic [31:0] faultMask_r;
    logic [31:0] runGate_nxt;
    logic [31:0] sleepGate_nxt;
    logic [31:0] deepGate_nxt;
    logic [31:0] runConfig_nxt;
    logic [31:0] faultStatus_nxt;
    logic [31:0] faultMask_nxt;
    clock_gate_pkg::unit_vec_t unitFaultInt;
    clock_gate_pkg::apb_req_t req;

    // The bus request travels as one bundle through the decode.
    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

    // Address decode; an unmapped address is answered with pslverr and writes nothing.
    wire selConfig = req.paddr == `CG_RUN_CLOCK_CONFIG_OFF;
    wire selRun = req.paddr == `CG_RUN_CLOCK_GATE_0_OFF;
    wire selSleep = req.paddr == `CG_SLEEP_CLOCK_GATE_0_OFF;
    wire selDeep = req.paddr == `CG_DEEP_SLEEP_CLOCK_GATE_0_OFF;
    wire selStatus = req.paddr == `CG_FAULT_STATUS_OFF;
    wire selMask = req.paddr == `CG_FAULT_MASK_OFF;
    wire addrHit = selConfig | selRun | selSleep | selDeep | selStatus | selMask;

    // One wait state: pready rises in the second access cycle, so read data come from a flop.
    wire accessWait = req.psel && req.penable && !pready;
    wire xferDone = req.psel && req.penable && pready;
    wire wrDone = xferDone && req.pwrite && addrHit;

    // Read multiplexer; reserved bits are never stored, so they read as zero.
    wire [31:0] readWord = selConfig ? runConfig_r :
                           selRun ? runGate_r :
                           selSleep ? sleepGate_r :
                           selDeep ? deepGate_r : // [RQ10]
                           selStatus ? faultStatus_r :
                           selMask ? faultMask_r : 32'h0000_0000;

    // Register writes; only implemented bits are kept, the rest stay read-only zero.
    assign runConfig_nxt = (wrDone && selConfig) ? (req.pwdata & `CG_CONFIG_MASK) : runConfig_r;
    assign runGate_nxt = (wrDone && selRun) ? (req.pwdata & `CG_GATE_MASK) : runGate_r; // [RQ4]
    assign sleepGate_nxt = (wrDone && selSleep) ? (req.pwdata & `CG_GATE_MASK) : sleepGate_r; // [RQ4]
    assign deepGate_nxt = (wrDone && selDeep) ? (req.pwdata & `CG_GATE_MASK) : deepGate_r; // [RQ10]
    assign faultMask_nxt = (wrDone && selMask) ? (req.pwdata & `CG_FAULT_BITS) : faultMask_r;

    // Fault events set sticky bits; a write of one clears, and a new fault in the same cycle wins.
    wire [31:0] faultSet = wordOf(unitFaultInt) & `CG_FAULT_BITS;
    wire [31:0] faultClr = (wrDone && selStatus) ? (req.pwdata & `CG_FAULT_BITS) : 32'h0000_0000;
    assign faultStatus_nxt = (faultStatus_r & ~faultClr) | faultSet;

    // Effective enable: the run register governs unless auto gating is on and the system sleeps.
    wire autoGating = runConfig_r[`CG_AUTO_CLOCK_GATING_BIT];
    wire [31:0] activeGate = !autoGating ? runGate_r : // [RQ5]
                             (powerMode == clock_gate_pkg::MODE_DEEP_SLEEP) ? deepGate_r : // [RQ12]
                             (powerMode == clock_gate_pkg::MODE_SLEEP) ? sleepGate_r : runGate_r;
    wire clock_gate_pkg::unit_vec_t clkEnNxt = gatesOf(activeGate); // [RQ1]
    wire irqNxt = |(faultStatus_nxt & faultMask_nxt);

    // Configuration and gate registers; the deep-sleep register resets with only the hibernation unit clocked.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            runConfig_r <= `CG_CONFIG_RESET;
            runGate_r <= `CG_GATE_RESET;
            sleepGate_r <= `CG_GATE_RESET;
            deepGate_r <= `CG_GATE_RESET; // [RQ3]
        end
        else
        begin
            runConfig_r <= runConfig_nxt;
            runGate_r <= runGate_nxt;
            sleepGate_r <= sleepGate_nxt;
            deepGate_r <= deepGate_nxt; // [RQ6] [RQ7] [RQ8] [RQ9]
        end
    end

    // Fault status and mask registers.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            faultStatus_r <= `CG_FAULT_RESET;
            faultMask_r <= `CG_FAULT_RESET;
        end
        else
        begin
            faultStatus_r <= faultStatus_nxt;
            faultMask_r <= faultMask_nxt;
        end
    end

    // Bus answer flops.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= accessWait;
            pslverr <= accessWait && !addrHit;
            prdata <= (accessWait && !req.pwrite) ? readWord : 32'h0000_0000;
        end
    end

    // Clock enables and interrupt are registered; a gate write shows at the unit one edge after it completes.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            unitClkEn <= gatesOf(`CG_GATE_RESET);
            irq <= 1'b0;
        end
        else
        begin
            unitClkEn <= clkEnNxt; // [RQ1]
            irq <= irqNxt;
        end
    end

    // Faults are judged against the enables the units actually see.
    unit_access_guard guard (
        .clk(clk),
        .rst_n(rst_n),
        .clkEn(unitClkEn),
        .unitAccess(unitAccess),
        .unitFault(unitFaultInt),
        .unitGrant(unitGrant)
    );

    // The fault pulse is repeated one cycle later, aligned with the status bit it sets.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            unitFault <= '0;
        end
        else
        begin
            unitFault <= unitFaultInt; // [RQ2]
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_deep_reset_value: assert property ($rose(rst_n) |-> deepGate_r == `CG_GATE_RESET) // [RQ3]
        else $error("Deep-sleep gate register left reset with a wrong value.");
    chk_reserved_zero: assert property ((deepGate_r & ~`CG_GATE_MASK) == 32'h0000_0000) // [RQ10]
        else $error("Reserved gate bit became nonzero.");
    chk_deep_governs: assert property (autoGating && powerMode == clock_gate_pkg::MODE_DEEP_SLEEP
        && $stable(deepGate_r) && $stable(powerMode) && $stable(autoGating)
        |=> unitClkEn == gatesOf($past(deepGate_r))) // [RQ1]
        else $error("Deep-sleep gates not applied in deep-sleep.");
    chk_run_when_manual: assert property (!autoGating && $stable(runGate_r) && $stable(autoGating)
        |=> unitClkEn == gatesOf($past(runGate_r))) // [RQ5]
        else $error("Run gates not applied with auto gating off.");
    chk_deep_ignored: assert property (powerMode != clock_gate_pkg::MODE_DEEP_SLEEP && $changed(deepGate_r)
        && $stable(powerMode) && $stable(runGate_r) && $stable(sleepGate_r) && $stable(autoGating)
        |=> $stable(unitClkEn)) // [RQ12]
        else $error("Deep-sleep register changed a clock outside deep-sleep.");
    chk_pwm_write: assert property (wrDone && selDeep |=> deepGate_r[`CG_PWM_BIT] == $past(req.pwdata[`CG_PWM_BIT])) // [RQ6]
        else $error("PWM gate did not take written value.");
    chk_adc_write: assert property (wrDone && selDeep |=> deepGate_r[`CG_ADC0_BIT] == $past(req.pwdata[`CG_ADC0_BIT])) // [RQ7]
        else $error("Converter gate did not take written value.");
    chk_wdt_write: assert property (wrDone && selDeep |=> deepGate_r[`CG_WATCHDOG_BIT] == $past(req.pwdata[`CG_WATCHDOG_BIT])) // [RQ9]
        else $error("Watchdog gate did not take written value.");
    chk_hib_write: assert property (wrDone && selDeep
        |=> deepGate_r[`CG_HIBERNATION_BIT] == $past(req.pwdata[`CG_HIBERNATION_BIT])) // [RQ8]
        else $error("Hibernation gate did not take written value.");
    chk_fault_sticky: assert property (unitFaultInt.pwm |=> faultStatus_r[`CG_PWM_BIT] && unitFault.pwm) // [RQ2]
        else $error("PWM fault did not set its status bit.");
    chk_sleep_separate: assert property (wrDone && selSleep |=> $stable(deepGate_r) && $stable(runGate_r)) // [RQ4]
        else $error("Sleep write disturbed another gate register.");
    chk_ready_timing: assert property (req.psel && !req.penable ##1 req.psel && req.penable |-> !pready ##1 pready)
        else $error("Bus answer not given after exactly one wait state.");

endmodule : deep_sleep_clock_gate_bank0
`default_nettype wire

// ### hdl/unit_access_guard.sv
// Turns accesses aimed at unclocked units other than hibernation into bus faults, one cycle after the access.
`default_nettype none
module unit_access_guard (
    input wire logic clk,
    input wire logic rst_n,
    input wire clock_gate_pkg::unit_vec_t clkEn,
    input wire clock_gate_pkg::unit_vec_t unitAccess,
    output clock_gate_pkg::unit_vec_t unitFault,
    output clock_gate_pkg::unit_vec_t unitGrant
);

    // The hibernation unit never faults; an access to it while unclocked is simply lost.
    wire clock_gate_pkg::unit_vec_t faultCanRaise = '{pwm: 1'b1, adc0: 1'b1, hibernation: 1'b0, watchdog: 1'b1};
    wire clock_gate_pkg::unit_vec_t faultNow = unitAccess & ~clkEn & faultCanRaise;
    wire clock_gate_pkg::unit_vec_t grantNow = unitAccess & clkEn;

    // Fault and grant answers are registered so that the fabric sees clean pulses.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            unitFault <= '0;
            unitGrant <= '0;
        end
        else
        begin
            unitFault <= faultNow; // [RQ2]
            unitGrant <= grantNow;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_fault_on_gated: assert property (unitAccess.watchdog && !clkEn.watchdog |=> unitFault.watchdog) // [RQ2]
        else $error("Access to unclocked watchdog gave no fault.");
    chk_hib_never_faults: assert property (!unitFault.hibernation) // [RQ8]
        else $error("Hibernation unit raised a fault.");

endmodule : unit_access_guard
`default_nettype wire

// ### test/tb.sv
// Self-checking bench for clock gate bank 0: APB registers, clock enables, unit faults and interrupt.
`include "clock_gate_map.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, runR, slpR, dpR, cfgR, staR, mskR, seed;
    clock_gate_pkg::power_mode_t powerMode;
    clock_gate_pkg::unit_vec_t unitAccess, unitClkEn, unitFault, unitGrant;
    logic [32:0] apbQ[$];
    logic [7:0] unitQ[$];
    logic [32:0] ea;
    logic [7:0] eu;
    int errors, compares;
    localparam int BIT_POS [4] = '{`CG_WATCHDOG_BIT, `CG_HIBERNATION_BIT, `CG_ADC0_BIT, `CG_PWM_BIT};
    localparam logic [11:0] OFFS [6] = '{`CG_RUN_CLOCK_CONFIG_OFF, `CG_RUN_CLOCK_GATE_0_OFF,
        `CG_SLEEP_CLOCK_GATE_0_OFF, `CG_DEEP_SLEEP_CLOCK_GATE_0_OFF, `CG_FAULT_STATUS_OFF, `CG_FAULT_MASK_OFF};
    localparam clock_gate_pkg::power_mode_t MODES [3] = '{clock_gate_pkg::MODE_RUN,
        clock_gate_pkg::MODE_SLEEP, clock_gate_pkg::MODE_DEEP_SLEEP};

    deep_sleep_clock_gate_bank0 i_deep_sleep_clock_gate_bank0 (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .powerMode(powerMode), .unitAccess(unitAccess), .unitClkEn(unitClkEn),
        .unitFault(unitFault), .unitGrant(unitGrant), .irq(irq));

    // Free-running 25 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Expected effective enables; a register only counts when auto gating selects it.
    function automatic clock_gate_pkg::unit_vec_t eff();
        logic [31:0] r;
        r = !cfgR[`CG_AUTO_CLOCK_GATING_BIT] ? runR : (powerMode == clock_gate_pkg::MODE_SLEEP) ? slpR :
            (powerMode == clock_gate_pkg::MODE_DEEP_SLEEP) ? dpR : runR;
        return {r[`CG_PWM_BIT], r[`CG_ADC0_BIT], r[`CG_HIBERNATION_BIT], r[`CG_WATCHDOG_BIT]};
    endfunction : eff

    function automatic logic [32:0] regVal(input logic [11:0] a);
        case (a)
            `CG_RUN_CLOCK_CONFIG_OFF: return {1'b0, cfgR};
            `CG_RUN_CLOCK_GATE_0_OFF: return {1'b0, runR};
            `CG_SLEEP_CLOCK_GATE_0_OFF: return {1'b0, slpR};
            `CG_DEEP_SLEEP_CLOCK_GATE_0_OFF: return {1'b0, dpR};
            `CG_FAULT_STATUS_OFF: return {1'b0, staR};
            `CG_FAULT_MASK_OFF: return {1'b0, mskR};
            default: return {1'b1, 32'h0000_0000};
        endcase
    endfunction : regVal

    // One APB transfer; the request is held until pready is seen high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
        int n;
        apbQ.push_back(e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        // A slave that never answers counts as a mismatch; the request is still released.
        if (pready !== 1'b1)
            errors++;
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Writes keep the model in step; reserved bits are dropped and status clears on ones.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [32:0] v;
        v = regVal(a);
        case (a)
            `CG_RUN_CLOCK_CONFIG_OFF: cfgR = d & `CG_CONFIG_MASK;
            `CG_RUN_CLOCK_GATE_0_OFF: runR = d & `CG_GATE_MASK;
            `CG_SLEEP_CLOCK_GATE_0_OFF: slpR = d & `CG_GATE_MASK;
            `CG_DEEP_SLEEP_CLOCK_GATE_0_OFF: dpR = d & `CG_GATE_MASK;
            `CG_FAULT_STATUS_OFF: staR = staR & ~d;
            `CG_FAULT_MASK_OFF: mskR = d & `CG_FAULT_BITS;
            default: ;
        endcase
        apb(1'b1, a, d, {v[32], 32'h0000_0000});
    endtask : wr

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000, regVal(a));
    endtask : rd

    // Lets enables and the interrupt settle, then compares them with the model.
    task automatic settle();
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("unitClkEn", unitClkEn, eff());
        chk("irq", irq, |(staR & mskR));
    endtask : settle

    // Strobes one unit; a clocked unit is granted, an unclocked one faults, hibernation never faults.
    task automatic acc(input int i);
        clock_gate_pkg::unit_vec_t u;
        u = '0;
        u[i] = 1'b1;
        if (eff() & u)
            unitQ.push_back({u, 4'b0000});
        else if (i != 1)
        begin
            unitQ.push_back({4'b0000, u});
            staR[BIT_POS[i]] = 1'b1;
        end
        @(posedge clk);
        unitAccess <= u;
        @(posedge clk);
        unitAccess <= '0;
        repeat (3) @(posedge clk);
    endtask : acc

    // Output watcher: takes the oldest note whenever an answer appears.
    always @(negedge clk)
    begin
        if (rst_n === 1'b1 && pready === 1'b1)
        begin
            ea = (apbQ.size() > 0) ? apbQ.pop_front() : 33'h1_DEAD_BEEF;
            chk("prdata", prdata, ea[31:0]);
            chk("pslverr", pslverr, ea[32]);
        end
        if (rst_n === 1'b1 && (unitGrant | unitFault) !== 4'b0000)
        begin
            eu = (unitQ.size() > 0) ? unitQ.pop_front() : 8'hFF;
            chk("unitGrant", unitGrant, eu[7:4]);
            chk("unitFault", unitFault, eu[3:0]);
        end
    end

    // Main sequence.
    initial
    begin
        {rst_n, psel, penable, pwrite, paddr, pwdata, unitAccess} = '0;
        powerMode = clock_gate_pkg::MODE_RUN;
        seed = 32'h0001_59E7;
        {errors, compares} = '0;
        {cfgR, staR, mskR} = '0;
        {runR, slpR, dpR} = {3{`CG_GATE_RESET}};
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        settle();
        foreach (OFFS[k]) rd(OFFS[k]);
        wr(12'h124, 32'hFFFF_FFFF);
        rd(12'h124);
        $display("reset and unmapped test done");
        repeat (3) foreach (OFFS[k]) begin wr(OFFS[k], rnd()); rd(OFFS[k]); end
        $display("register access test done");
        // Software enables the units it needs in each gate register before use.
        wr(`CG_RUN_CLOCK_GATE_0_OFF, 32'h0010_0000);
        wr(`CG_SLEEP_CLOCK_GATE_0_OFF, 32'h0001_0040);
        wr(`CG_DEEP_SLEEP_CLOCK_GATE_0_OFF, 32'h0000_0008);
        wr(`CG_FAULT_MASK_OFF, 32'hFFFF_FFFF);
        for (int g = 0; g < 2; g++)
        begin
            wr(`CG_RUN_CLOCK_CONFIG_OFF, g ? 32'h0800_0000 : 32'h0000_0000);
            foreach (MODES[m])
            begin
                @(posedge clk);
                powerMode <= MODES[m];
                settle();
                for (int i = 0; i < 4; i++) acc(i);
                settle();
                rd(`CG_FAULT_STATUS_OFF);
                wr(`CG_FAULT_MASK_OFF, rnd());
                settle();
                wr(`CG_FAULT_STATUS_OFF, 32'hFFFF_FFFF);
                settle();
            end
        end
        $display("gating and fault test done");
        chk("apbQ", apbQ.size(), 0);
        chk("unitQ", unitQ.size(), 0);
        wrap_up();
    end

    // Watchdog against a hung handshake.
    initial
    begin
        repeat (8000) @(posedge clk);
        errors++;
        wrap_up();
    end
endmodule : tb
`default_nettype wire
